//--- hw/vlan_table_lookup.sv
`timescale 1ns/1ps
module vlan_table_lookup
   import vlan_pkg::*;
#(
   parameter int ENTRIES = 16
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic [AXI_AW-1:0] s_axil_awaddr_i,
   input  wire logic              s_axil_awvalid_i,
   output logic                   s_axil_awready_o,
   input  wire logic [AXI_DW-1:0] s_axil_wdata_i,
   input  wire logic [3:0]        s_axil_wstrb_i,
   input  wire logic              s_axil_wvalid_i,
   output logic                   s_axil_wready_o,
   output logic      [1:0]        s_axil_bresp_o,
   output logic                   s_axil_bvalid_o,
   input  wire logic              s_axil_bready_i,
   input  wire logic [AXI_AW-1:0] s_axil_araddr_i,
   input  wire logic              s_axil_arvalid_i,
   output logic                   s_axil_arready_o,
   output logic      [AXI_DW-1:0] s_axil_rdata_o,
   output logic      [1:0]        s_axil_rresp_o,
   output logic                   s_axil_rvalid_o,
   input  wire logic              s_axil_rready_i,
   input  wire logic              lkp_valid_i,
   output logic                   lkp_ready_o,
   input  wire logic [PORT_W-1:0] lkp_port_i,
   input  wire logic              lkp_tagged_i,
   input  wire logic [VID_W-1:0]  lkp_tag_vid_i,
   output logic                   addr_req_valid_o,
   output logic      [FID_W-1:0]  addr_req_fid_o,
   input  wire logic              addr_rsp_valid_i,
   input  wire logic              da_hit_i,
   input  wire logic [MEMB_W-1:0] da_ports_i,
   input  wire logic              sa_hit_i,
   output logic                   res_valid_o,
   output logic                   res_drop_o,
   output logic                   res_learn_o,
   output logic      [MEMB_W-1:0] res_ports_o,
   output logic      [VID_W-1:0]  res_vid_o,
   output logic      [FID_W-1:0]  res_fid_o
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } state_type;

   state_type          state;
   logic               mode;
   logic [IAC_W-1:0]   iac;
   logic [HI_W-1:0]    data_high;
   logic [LO_W-1:0]    data_low;
   logic [VID_W-1:0]   pvid [MEMB_W];
   logic [CNT_W-1:0]   drop_cnt;
   logic [CNT_W-1:0]   learn_cnt;
   logic [AXI_AW-1:0]  waddr;
   logic [AXI_DW-1:0]  wdata;
   logic [3:0]         wstrb;
   logic               aw_got;
   logic               w_got;
   logic               do_wr;
   logic               wr_hit;
   logic [AXI_DW-1:0]  wr_old;
   logic [AXI_DW-1:0]  wr_new;
   logic               rd_hit;
   logic [AXI_DW-1:0]  rd_word;
   logic [IAC_W-1:0]   cmd;
   logic               cmd_go;
   logic               tbl_wr;
   logic [ENTRY_W-1:0] tbl_rd;
   logic               take;
   logic [MEMB_W-1:0]  ing_mask;
   logic [VID_W-1:0]   assigned_vid;
   logic               find_hit;
   logic [ENTRY_W-1:0] find_entry;
   logic               entry_ok;
   logic               drop_now;
   logic [MEMB_W-1:0]  memb_q;
   logic [MEMB_W-1:0]  ing_q;

   function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
                                               input logic [AXI_DW-1:0] d,
                                               input logic [3:0]        s);
      logic [AXI_DW-1:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Register view shared by reads and byte-merged writes
   function automatic logic [AXI_DW+1-1:0] view(input logic [AXI_AW-1:0] a);
      logic [AXI_DW-1:0] w;
      logic              h;
      w = '0;
      h = 1'b1;
      case (a)
         OFF_GSC2: w[MODE_BIT] = mode;
         OFF_IAC:  w[IAC_W-1:0] = iac;
         OFF_IDH:  w[HI_W-1:0] = data_high;
         OFF_IDL:  w[LO_W-1:0] = data_low;
         OFF_STAT: w = {learn_cnt, drop_cnt};
         default: begin
            h = 1'b0;
            for (int p = 0; p < MEMB_W; p++) begin
               if (a == OFF_PVID0 + AXI_AW'(p) * WORD_STEP) begin
                  h = 1'b1;
                  w[VID_W-1:0] = pvid[p];
               end
            end
         end
      endcase
      return {h, w};
   endfunction

   always_comb begin
      do_wr = aw_got && w_got && !s_axil_bvalid_o;
      {wr_hit, wr_old} = view(waddr);
      wr_new = merge(wr_old, wdata, wstrb);
      {rd_hit, rd_word} = view(s_axil_araddr_i);
      cmd = wr_new[IAC_W-1:0];
      cmd_go = do_wr && waddr == OFF_IAC && cmd[TBL_LSB +: TBL_W] == TBL_VLAN;
      tbl_wr = cmd_go && !cmd[CMD_RD_BIT];
   end

   // Write address and data may arrive in either order
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         aw_got           <= 1'b0;
         w_got            <= 1'b0;
         waddr            <= '0;
         wdata            <= '0;
         wstrb            <= '0;
         s_axil_awready_o <= 1'b0;
         s_axil_wready_o  <= 1'b0;
         s_axil_bvalid_o  <= 1'b0;
         s_axil_bresp_o   <= RESP_OK;
      end else begin
         if (s_axil_awvalid_i && s_axil_awready_o) begin
            aw_got           <= 1'b1;
            waddr            <= s_axil_awaddr_i;
            s_axil_awready_o <= 1'b0;
         end else if (!aw_got && !s_axil_bvalid_o) begin
            s_axil_awready_o <= 1'b1;
         end
         if (s_axil_wvalid_i && s_axil_wready_o) begin
            w_got           <= 1'b1;
            wdata           <= s_axil_wdata_i;
            wstrb           <= s_axil_wstrb_i;
            s_axil_wready_o <= 1'b0;
         end else if (!w_got && !s_axil_bvalid_o) begin
            s_axil_wready_o <= 1'b1;
         end
         if (do_wr) begin
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            s_axil_bvalid_o <= 1'b1;
            s_axil_bresp_o  <= wr_hit ? RESP_OK : RESP_ERR;
         end else if (s_axil_bvalid_o && s_axil_bready_i) begin
            s_axil_bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_axil_arready_o <= 1'b0;
         s_axil_rvalid_o  <= 1'b0;
         s_axil_rdata_o   <= '0;
         s_axil_rresp_o   <= RESP_OK;
      end else if (s_axil_arvalid_i && s_axil_arready_o) begin
         s_axil_arready_o <= 1'b0;
         s_axil_rvalid_o  <= 1'b1;
         s_axil_rdata_o   <= rd_word;
         s_axil_rresp_o   <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (s_axil_rvalid_o && s_axil_rready_i) begin
         s_axil_rvalid_o  <= 1'b0;
      end else if (!s_axil_rvalid_o) begin
         s_axil_arready_o <= 1'b1;
      end
   end

   // Software registers; a VLAN read command refreshes the data pair
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mode      <= 1'b0;
         iac       <= '0;
         data_high <= '0;
         data_low  <= '0;
         for (int p = 0; p < MEMB_W; p++) begin
            pvid[p] <= PVID_RST;
         end
      end else if (do_wr) begin
         case (waddr)
            OFF_GSC2: mode <= wr_new[MODE_BIT];
            OFF_IAC:  iac <= cmd;
            OFF_IDH:  data_high <= wr_new[HI_W-1:0];
            OFF_IDL:  data_low <= wr_new[LO_W-1:0];
            default: begin
               for (int p = 0; p < MEMB_W; p++) begin
                  if (waddr == OFF_PVID0 + AXI_AW'(p) * WORD_STEP) begin
                     pvid[p] <= wr_new[VID_W-1:0];
                  end
               end
            end
         endcase
         if (cmd_go && cmd[CMD_RD_BIT]) begin
            {data_high, data_low} <= tbl_rd;
         end
      end
   end

   vlan_entry_table #(
      .ENTRIES (ENTRIES)
   ) u_table (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .wr_en_i      (tbl_wr),
      .wr_idx_i     (cmd[IDX_W-1:0]),
      .wr_data_i    ({data_high, data_low}),
      .rd_idx_i     (cmd[IDX_W-1:0]),
      .rd_data_o    (tbl_rd),
      .find_vid_i   (assigned_vid),
      .find_hit_o   (find_hit),
      .find_entry_o (find_entry)
   );

   // Classification of the offered frame
   always_comb begin
      take = lkp_valid_i && lkp_ready_o && state == ST_IDLE;
      ing_mask = '0;
      assigned_vid = PVID_RST;
      if (int'(lkp_port_i) < MEMB_W) begin
         ing_mask = MEMB_W'(1) << lkp_port_i;
         assigned_vid = pvid[lkp_port_i];
      end
      if (lkp_tagged_i && lkp_tag_vid_i != NULL_VID) begin
         assigned_vid = lkp_tag_vid_i;
      end
      entry_ok = find_hit && find_entry[VALID_BIT];
      drop_now = mode && !entry_ok;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state            <= ST_IDLE;
         lkp_ready_o      <= 1'b0;
         addr_req_valid_o <= 1'b0;
         addr_req_fid_o   <= FID_NONE;
         res_valid_o      <= 1'b0;
         res_drop_o       <= 1'b0;
         res_learn_o      <= 1'b0;
         res_ports_o      <= '0;
         res_vid_o        <= '0;
         res_fid_o        <= FID_NONE;
         memb_q           <= '0;
         ing_q            <= '0;
      end else begin
         addr_req_valid_o <= 1'b0;
         res_valid_o      <= 1'b0;
         case (state)
            ST_IDLE: begin
               lkp_ready_o <= 1'b1;
               if (take) begin
                  res_vid_o <= assigned_vid;
                  ing_q     <= ing_mask;
                  if (drop_now) begin
                     res_valid_o <= 1'b1;
                     res_drop_o  <= 1'b1;
                     res_learn_o <= 1'b0;
                     res_ports_o <= '0;
                     res_fid_o   <= FID_NONE;
                  end else begin
                     // Mode off: table unused, member set is every port, so a DA miss floods to every port except the ingress port
                     memb_q <= mode ? find_entry[MEMB_LSB +: MEMB_W] : ALL_PORTS;
                     addr_req_fid_o   <= mode ? find_entry[FID_LSB +: FID_W] : FID_NONE;
                     res_fid_o        <= mode ? find_entry[FID_LSB +: FID_W] : FID_NONE;
                     addr_req_valid_o <= 1'b1;
                     lkp_ready_o      <= 1'b0;
                     state            <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (addr_rsp_valid_i) begin
                  res_valid_o <= 1'b1;
                  res_drop_o  <= 1'b0;
                  res_learn_o <= !sa_hit_i;
                  if (da_hit_i) begin
                     res_ports_o <= da_ports_i & ~ing_q;
                  end else begin
                     res_ports_o <= memb_q & ~ing_q;
                  end
                  lkp_ready_o <= 1'b1;
                  state       <= ST_IDLE;
               end
            end
            default: begin
               lkp_ready_o <= 1'b0;
               state       <= ST_IDLE;
            end
         endcase
      end
   end

   // Counters wrap; software samples them as deltas
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         drop_cnt  <= '0;
         learn_cnt <= '0;
      end else if (res_valid_o) begin
         drop_cnt  <= drop_cnt + CNT_W'(res_drop_o);
         learn_cnt <= learn_cnt + CNT_W'(res_learn_o);
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   a_mode_gates_drop: assert property (res_valid_o && res_drop_o |-> mode)
      else $error("drop without vlan mode");
   a_drop_no_learn: assert property (res_valid_o && res_drop_o |-> !res_learn_o && res_ports_o == '0)
      else $error("dropped frame learned or forwarded");
   a_invalid_drops: assert property (take && mode && !entry_ok |=> res_valid_o && res_drop_o)
      else $error("invalid entry not dropped");
   a_untagged_pvid: assert property (take && int'(lkp_port_i) < MEMB_W && !lkp_tagged_i
                                     |=> res_vid_o == pvid[$past(lkp_port_i)])
      else $error("untagged frame not given port vlan");
   a_tag_vid_used: assert property (take && lkp_tagged_i && lkp_tag_vid_i != NULL_VID
                                    |=> res_vid_o == $past(lkp_tag_vid_i))
      else $error("tag vlan not used");
   a_fid_query: assert property (take && mode && entry_ok
                                 |=> addr_req_valid_o && addr_req_fid_o == $past(find_entry[FID_LSB +: FID_W]))
      else $error("filter id not sent to address lookup");
   a_flood_members: assert property (state == ST_WAIT && addr_rsp_valid_i && !da_hit_i
                                     |=> res_valid_o && res_ports_o == (memb_q & ~ing_q))
      else $error("miss not flooded to members");
   a_learn_on_miss: assert property (state == ST_WAIT && addr_rsp_valid_i
                                     |=> res_learn_o == !$past(sa_hit_i))
      else $error("source learning wrong");
   a_bresp_holds: assert property (s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o)
      else $error("write response dropped");
   a_ind_read: assert property (cmd_go && cmd[CMD_RD_BIT] ##1 !do_wr
                                |-> {data_high, data_low} == $past(tbl_rd))
      else $error("indirect read data wrong");

   c_drop: cover property (res_valid_o && res_drop_o);
   c_flood: cover property (addr_rsp_valid_i && !da_hit_i && state == ST_WAIT);
   c_learn: cover property (res_valid_o && res_learn_o);
   c_ind_rw: cover property (tbl_wr ##[1:20] (cmd_go && cmd[CMD_RD_BIT]));
endmodule

//--- hw/vlan_pkg.sv
package vlan_pkg;
   localparam int ENTRY_W   = 20;
   localparam int VID_W     = 12;
   localparam int FID_W     = 4;
   localparam int MEMB_W    = 3;
   localparam int PORT_W    = 2;
   localparam int IDX_W     = 4;
   localparam int VALID_BIT = 19;
   localparam int MEMB_LSB  = 16;
   localparam int FID_LSB   = 12;
   localparam int VID_LSB   = 0;
   localparam int HI_W      = 4;
   localparam int LO_W      = 16;
   localparam int IAC_W     = 16;
   localparam int CNT_W     = 16;
   localparam logic [ENTRY_W-1:0] ENTRY_RST = 20'hf0001;
   localparam logic [VID_W-1:0]   PVID_RST  = 12'h001;
   localparam logic [VID_W-1:0]   NULL_VID  = 12'h000;
   localparam logic [FID_W-1:0]   FID_NONE  = 4'h0;
   localparam logic [MEMB_W-1:0]  ALL_PORTS = 3'h7;
   localparam int MODE_BIT   = 15;
   localparam int CMD_RD_BIT = 12;
   localparam int TBL_LSB    = 10;
   localparam int TBL_W      = 2;
   localparam logic [TBL_W-1:0] TBL_VLAN = 2'h1;
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam logic [AXI_AW-1:0] OFF_GSC2  = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_IAC   = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_IDH   = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_IDL   = 8'h0c;
   localparam logic [AXI_AW-1:0] OFF_PVID0 = 8'h10;
   localparam logic [AXI_AW-1:0] OFF_STAT  = 8'h1c;
   localparam logic [AXI_AW-1:0] WORD_STEP = 8'h04;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

//--- hw/vlan_entry_table.sv
`timescale 1ns/1ps
module vlan_entry_table
   import vlan_pkg::*;
#(
   parameter int ENTRIES = 16
) (
   input  wire logic               sys_clk_i,
   input  wire logic               rst_i,
   input  wire logic               wr_en_i,
   input  wire logic [IDX_W-1:0]   wr_idx_i,
   input  wire logic [ENTRY_W-1:0] wr_data_i,
   input  wire logic [IDX_W-1:0]   rd_idx_i,
   output logic      [ENTRY_W-1:0] rd_data_o,
   input  wire logic [VID_W-1:0]   find_vid_i,
   output logic                    find_hit_o,
   output logic      [ENTRY_W-1:0] find_entry_o
);
   logic [ENTRY_W-1:0] mem [ENTRIES];

   if (ENTRIES < 1 || ENTRIES > (1 << IDX_W)) begin : g_chk
      $error("ENTRIES out of range");
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < ENTRIES; i++) begin
            mem[i] <= ENTRY_RST;
         end
      end else if (wr_en_i && int'(wr_idx_i) < ENTRIES) begin
         mem[wr_idx_i] <= wr_data_i;
      end
   end

   always_comb begin
      rd_data_o = '0;
      if (int'(rd_idx_i) < ENTRIES) begin
         rd_data_o = mem[rd_idx_i];
      end
   end

   // Lowest index wins when several entries carry the same VLAN
   always_comb begin
      find_hit_o   = 1'b0;
      find_entry_o = '0;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (mem[i][VID_LSB +: VID_W] == find_vid_i) begin
            find_hit_o   = 1'b1;
            find_entry_o = mem[i];
         end
      end
   end
endmodule

//--- sim/addr_table_model.sv
`timescale 1ns/1ps
module addr_table_model
   import vlan_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              req_valid_i,
   input  wire logic [FID_W-1:0]  req_fid_i,
   input  wire logic [3:0]        delay_i,
   input  wire logic              da_hit_cfg_i,
   input  wire logic [MEMB_W-1:0] da_ports_cfg_i,
   input  wire logic              sa_hit_cfg_i,
   output logic                   rsp_valid_o,
   output logic                   da_hit_o,
   output logic      [MEMB_W-1:0] da_ports_o,
   output logic                   sa_hit_o
);
   logic [3:0] cnt;
   logic       busy;
   logic [FID_W-1:0] filter_identifier;

   // Answer a combined filter plus address lookup after a chosen delay
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         busy        <= 1'b0;
         cnt         <= 4'h0;
         filter_identifier         <= FID_NONE;
         rsp_valid_o <= 1'b0;
      end else begin
         rsp_valid_o <= 1'b0;
         if (req_valid_i) begin
            busy <= 1'b1;
            cnt  <= delay_i;
            filter_identifier  <= req_fid_i;
         end else if (busy) begin
            if (cnt == 4'h0) begin
               busy        <= 1'b0;
               rsp_valid_o <= 1'b1;
            end else begin
               cnt <= cnt - 4'h1;
            end
         end
      end
   end

   // Outside the answer pulse the lines carry junk, never the answer
   assign da_hit_o   = rsp_valid_o ? da_hit_cfg_i : ~da_hit_cfg_i;
   assign da_ports_o = rsp_valid_o ? da_ports_cfg_i : ~da_ports_cfg_i;
   assign sa_hit_o   = rsp_valid_o ? sa_hit_cfg_i : ~sa_hit_cfg_i;
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench
   import vlan_pkg::*;
;
   localparam int LIM = 200;
   logic sys_clk, rst;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, r;
   logic lkp_valid, lkp_ready, lkp_tagged, aq_valid, as_valid, da_hit, sa_hit;
   logic res_valid, res_drop, res_learn;
   logic [1:0]  lkp_port;
   logic [11:0] lkp_vid, res_vid;
   logic [3:0]  aq_fid, res_fid, dly;
   logic [2:0]  da_ports, res_ports, dap;
   logic dah, sah;
   logic [19:0] e;
   logic [20:0] res;
   logic [31:0] d;
   int fails = 0;
   int checked = 0;

   vlan_table_lookup u_vlan_table_lookup (.sys_clk_i(sys_clk), .rst_i(rst),
      .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
      .s_axil_wdata_i(wdata), .s_axil_wstrb_i(4'hf), .s_axil_wvalid_i(wvalid), .s_axil_wready_o(wready),
      .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid), .s_axil_bready_i(bready),
      .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid), .s_axil_arready_o(arready),
      .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready),
      .lkp_valid_i(lkp_valid), .lkp_ready_o(lkp_ready), .lkp_port_i(lkp_port),
      .lkp_tagged_i(lkp_tagged), .lkp_tag_vid_i(lkp_vid), .addr_req_valid_o(aq_valid),
      .addr_req_fid_o(aq_fid), .addr_rsp_valid_i(as_valid), .da_hit_i(da_hit),
      .da_ports_i(da_ports), .sa_hit_i(sa_hit), .res_valid_o(res_valid), .res_drop_o(res_drop),
      .res_learn_o(res_learn), .res_ports_o(res_ports), .res_vid_o(res_vid), .res_fid_o(res_fid));

   addr_table_model u_addr_table_model (.sys_clk_i(sys_clk), .rst_i(rst), .req_valid_i(aq_valid),
      .req_fid_i(aq_fid), .delay_i(dly), .da_hit_cfg_i(dah), .da_ports_cfg_i(dap),
      .sa_hit_cfg_i(sah), .rsp_valid_o(as_valid), .da_hit_o(da_hit), .da_ports_o(da_ports),
      .sa_hit_o(sa_hit));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic give_up(input int n);
      if (n >= LIM) begin
         fails++;
         end_of_test();
      end
   endtask

   // Ready and response handshakes are sampled on the edge, before outputs move
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      int n;
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      for (n = 0; n < LIM; n++) begin
         @(posedge sys_clk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid) break;
      end
      resp = bresp;
      give_up(n);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      logic ar;
      ar = 1'b1;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < LIM; n++) begin
         @(posedge sys_clk);
         if (ar && arready) begin
            ar = 1'b0;
            arvalid <= 1'b0;
         end
         if (rvalid) break;
      end
      v = rdata;
      resp = rresp;
      give_up(n);
   endtask

   task automatic rd_entry(input logic [3:0] idx, output logic [19:0] ent);
      logic [31:0] h, l;
      logic [1:0] rs;
      axi_wr(OFF_IAC, {19'h0, 1'b1, TBL_VLAN, 6'h00, idx}, rs);
      axi_rd(OFF_IDH, h, rs);
      axi_rd(OFF_IDL, l, rs);
      `CHK(rs, RESP_OK)
      ent = {h[3:0], l[15:0]};
   endtask

   task automatic wr_entry(input logic [3:0] idx, input logic [19:0] ent);
      logic [1:0] rs;
      axi_wr(OFF_IDH, {28'h0, ent[19:16]}, rs);
      axi_wr(OFF_IDL, {16'h0, ent[15:0]}, rs);
      axi_wr(OFF_IAC, {19'h0, 1'b0, TBL_VLAN, 6'h00, idx}, rs);
      `CHK(rs, RESP_OK)
   endtask

   // Result packed as drop, learn, ports, vlan, filter
   task automatic lkp(input logic [1:0] p, input logic t, input logic [11:0] v, output logic [20:0] o);
      int n;
      logic tk;
      tk = 1'b1;
      lkp_valid <= 1'b1;
      lkp_port <= p;
      lkp_tagged <= t;
      lkp_vid <= v;
      for (n = 0; n < LIM; n++) begin
         @(posedge sys_clk);
         if (tk && lkp_ready) begin
            tk = 1'b0;
            lkp_valid <= 1'b0;
         end
         if (res_valid) break;
      end
      o = {res_drop, res_learn, res_ports, res_vid, res_fid};
      give_up(n);
   endtask

   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
      {lkp_valid, lkp_port, lkp_tagged, lkp_vid, dly, dah, dap, sah} = '0;
      bready = 1'b1;
      rready = 1'b1;
      rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rd_entry(4'h0, e);
      `CHK(e, 20'hf0001)
      rd_entry(4'hf, e);
      `CHK(e, 20'hf0001)
      axi_wr(8'h20, 32'h1234, r);
      `CHK(r, RESP_ERR)
      axi_rd(8'h24, d, r);
      `CHK(r, RESP_ERR)
      wr_entry(4'h6, 20'hd50a0);
      wr_entry(4'h7, 20'h730b0);
      rd_entry(4'h6, e);
      `CHK(e, 20'hd50a0)
      rd_entry(4'h7, e);
      `CHK(e, 20'h730b0)
      // Read command for another table must leave the data pair alone
      axi_wr(OFF_IAC, 32'h1006, r);
      axi_rd(OFF_IDL, d, r);
      `CHK(d[15:0], 16'h30b0)
      axi_wr(OFF_GSC2, 32'h8000, r);
      axi_wr(OFF_PVID0 + WORD_STEP, 32'h0a0, r);
      dly <= 4'h3;
      lkp(2'h0, 1'b1, 12'h0a0, res);
      `CHK(res, {2'b01, 3'b100, 12'h0a0, 4'h5})
      `CHK(aq_fid, 4'h5)
      dah <= 1'b1;
      dap <= 3'b011;
      sah <= 1'b1;
      dly <= 4'h0;
      lkp(2'h2, 1'b1, 12'h0a0, res);
      `CHK(res, {2'b00, 3'b011, 12'h0a0, 4'h5})
      lkp(2'h0, 1'b1, 12'h0b0, res);
      `CHK(res[20:16], {2'b10, 3'b000})
      lkp(2'h0, 1'b1, 12'h3ff, res);
      `CHK(res[20], 1'b1)
      dah <= 1'b0;
      sah <= 1'b0;
      lkp(2'h1, 1'b0, 12'h0b0, res);
      `CHK(res, {2'b01, 3'b101, 12'h0a0, 4'h5})
      lkp(2'h0, 1'b1, NULL_VID, res);
      `CHK(res, {2'b01, 3'b110, 12'h001, 4'h0})
      axi_rd(OFF_STAT, d, r);
      `CHK(d[15:0], 16'h0002)
      axi_wr(OFF_GSC2, 32'h0, r);
      lkp(2'h0, 1'b1, 12'h0b0, res);
      `CHK(res, {2'b01, 3'b110, 12'h0b0, 4'h0})
      `CHK(aq_fid, FID_NONE)
      end_of_test();
   end
endmodule
